/* File: design/key_lockout.sv */
// Neighbour key lockout: one reported object per group
`timescale 1ns/1ns
`default_nettype none
module key_lockout (
  // Sensed keys
  input wire logic [15:0] i_raw,
  input wire logic [159:0] i_delta,
  input wire logic [31:0] i_group,
  input wire logic [15:0] i_smask,
  // Group owners
  input wire logic [14:0] i_owner,
  output logic [14:0] o_owner,
  output logic [15:0] o_det
);

  logic s_touch;
  logic [1:0] s_grp;
  logic [9:0] s_str;
  logic [4:0] own [3];

  always_comb begin
    logic [9:0] bs;
    logic [4:0] cur;
    logic [4:0] best;
    logic [1:0] cg;
    logic ct;
    bs = '0;
    cur = tsk_pkg::OWN_NONE;
    best = tsk_pkg::OWN_NONE;
    cg = tsk_pkg::GRP_NONE;
    ct = 1'b0;
    s_touch = |(i_raw & i_smask);
    s_grp = i_group[1:0];
    s_str = '0;
    for (int k = 0; k < 16; k++) begin
      if (i_raw[k] && i_smask[k] && i_delta[10*k +: 10] > s_str) begin
        s_str = i_delta[10*k +: 10];
      end
    end
    for (int g = 0; g < 3; g++) begin
      cur = i_owner[5*g +: 5];
      ct = (cur == tsk_pkg::OWN_SLIDER) ? s_touch :
           (cur[4] ? 1'b0 : i_raw[cur[3:0]] & ~i_smask[cur[3:0]]);
      cg = (cur == tsk_pkg::OWN_SLIDER) ? s_grp : i_group[2*cur[3:0] +: 2];
      best = tsk_pkg::OWN_NONE;
      bs = '0;
      if (ct && cg == 2'(g + 1)) begin
        best = cur;
      end else begin
        for (int k = 0; k < 16; k++) begin
          if (i_raw[k] && !i_smask[k] && i_group[2*k +: 2] == 2'(g + 1) &&
              (best == tsk_pkg::OWN_NONE || i_delta[10*k +: 10] > bs)) begin
            best = 5'(k);
            bs = i_delta[10*k +: 10];
          end
        end
        if (s_touch && s_grp == 2'(g + 1) &&
            (best == tsk_pkg::OWN_NONE || s_str > bs)) begin
          best = tsk_pkg::OWN_SLIDER;
        end
      end
      own[g] = best;
    end
    for (int k = 0; k < 16; k++) begin
      cg = i_smask[k] ? s_grp : i_group[2*k +: 2];
      if (cg == tsk_pkg::GRP_NONE) begin
        o_det[k] = i_raw[k];
      end else if (i_smask[k]) begin
        o_det[k] = i_raw[k] && own[cg - 2'h1] == tsk_pkg::OWN_SLIDER;
      end else begin
        o_det[k] = i_raw[k] && own[cg - 2'h1] == 5'(k);
      end
    end
    o_owner = {own[2], own[1], own[0]};
  end

endmodule
`default_nettype wire

/* File: design/slider_position.sv */
// Slider position by delta interpolation around the peak key
`timescale 1ns/1ns
`default_nettype none
module slider_position (
  // Slider keys
  input wire logic [79:0] i_delta,
  input wire logic [7:0] i_touch,
  input wire logic [3:0] i_count,
  input wire logic [3:0] i_res,
  // Result
  output logic [7:0] o_pos
);

  always_comb begin
    logic [2:0] p;
    logic [9:0] dp;
    logic [9:0] dl;
    logic [9:0] dr;
    logic [11:0] sum;
    logic signed [11:0] diff;
    logic signed [20:0] num;
    logic signed [20:0] x;
    logic [11:0] span;
    logic [19:0] scaled;
    p = '0;
    dp = '0;
    for (int k = 0; k < 8; k++) begin
      if (4'(k) < i_count && i_touch[k] && i_delta[10*k +: 10] > dp) begin
        p = 3'(k);
        dp = i_delta[10*k +: 10];
      end
    end
    dl = (p != 3'h0) ? i_delta[10*(p - 3'h1) +: 10] : 10'h000;
    dr = (4'(p) + 4'h1 < i_count) ? i_delta[10*(p + 3'h1) +: 10] : 10'h000;
    sum = 12'(dl) + 12'(dp) + 12'(dr);
    if (sum == 12'h000) begin
      sum = 12'h001;
    end
    diff = $signed(12'(dr)) - $signed(12'(dl));
    num = diff;
    num = num <<< 8;
    // Centroid shift stays inside one key pitch either way
    x = $signed({10'h000, p, 8'h00}) + num / $signed({9'h000, sum});
    span = {i_count - 4'h1, 8'h00};
    if (x < 0) begin
      x = '0;
    end else if (x > $signed({9'h000, span})) begin
      x = $signed({9'h000, span});
    end
    scaled = (20'(x[11:0]) * 20'h000ff) / 20'({4'h0, i_count - 4'h1});
    scaled = scaled >> 8;
    o_pos = 8'(scaled) >> (tsk_pkg::MAX_RES - i_res);
  end

endmodule
`default_nettype wire

/* File: design/touch_slider_core.sv */
// Slider, key lockout and start-up sequencing for the touch matrix
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - Slider uses receive line zero, from drive line zero upward consecutively.
// - Slider key count programmable; remaining keys on that line act normally.
// - Slider position unsigned, resolution programmable from 2 to 8 bits.
// - Whole slider counts as one object for neighbour key lockout.
// - Up to three groups; at most one object reported per group.
// - Group latches dominant key; others suppressed until it is released.
// - Per-key group number: 1 to 3 join a group, 0 opts out.
// - Slider keys never suppress each other; several may report at once.
// - Slider and keys in one group suppress each other, first touch wins.
// - After reset about 70 ms init, then change low and 15-scan calibration.
// - Change notification asserts whenever any key status bit changes.
// - Acquisition and processing run on a fixed 16 ms cycle.
module touch_slider_core #(
  parameter int unsigned INIT_CYCLES = tsk_pkg::INIT_CYCLES,
  parameter int unsigned CYCLE_CYCLES = tsk_pkg::CYCLE_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Acquisition results
  input wire logic i_scan_done,
  input wire logic [15:0] i_raw,
  input wire logic [159:0] i_delta,
  // Configuration
  input wire logic [3:0] i_slider_keys,
  input wire logic [3:0] i_slider_res,
  input wire logic [31:0] i_group,
  input wire logic i_status_read,
  // Results
  output logic [15:0] o_key_status,
  output logic o_slider_det,
  output logic [7:0] o_slider_pos,
  output logic o_calibrating,
  output logic o_cycle_start,
  // Open-drain change pin
  output logic o_change_o,
  output logic o_change_oe_n
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    tsk_pkg::phase_t phase;
    logic [tsk_pkg::INIT_CNT_W-1:0] init_cnt;
    logic [tsk_pkg::CYC_CNT_W-1:0] cyc_cnt;
    logic [3:0] cal_cnt;
    logic [15:0] keys;
    logic slider_det;
    logic [7:0] pos;
    logic [14:0] owners;
    logic cycle_start;
    logic calibrating;
    logic change_o;
    logic change_oe_n;
  } core_state_t;

  localparam logic [tsk_pkg::INIT_CNT_W-1:0] INIT_LAST =
    tsk_pkg::INIT_CNT_W'(INIT_CYCLES - 1);
  localparam logic [tsk_pkg::CYC_CNT_W-1:0] CYC_LAST =
    tsk_pkg::CYC_CNT_W'(CYCLE_CYCLES - 1);

  core_state_t state_reg;
  core_state_t state_next;

  // ----------------------------------------
  // Slider membership
  // ----------------------------------------
  logic [3:0] scount;
  logic [3:0] sres;
  logic [15:0] smask;
  logic [15:0] grp0;

  always_comb begin
    if (i_slider_keys < tsk_pkg::MIN_SLIDER) begin
      scount = 4'h0;
    end else if (i_slider_keys > tsk_pkg::MAX_SLIDER) begin
      scount = tsk_pkg::MAX_SLIDER;
    end else begin
      scount = i_slider_keys;
    end
    if (i_slider_res < tsk_pkg::MIN_RES) begin
      sres = tsk_pkg::MIN_RES;
    end else if (i_slider_res > tsk_pkg::MAX_RES) begin
      sres = tsk_pkg::MAX_RES;
    end else begin
      sres = i_slider_res;
    end
  end

  // Keys 0..7 sit on receive line zero in drive line order
  for (genvar k = 0; k < 16; k++) begin : g_mask
    assign smask[k] = (k < 8) && (4'(k) < scount);
    assign grp0[k] = (i_group[2*k +: 2] == tsk_pkg::GRP_NONE) && !smask[k];
  end

  // ----------------------------------------
  // Lockout and position
  // ----------------------------------------
  logic [15:0] lock_det;
  logic [14:0] lock_owner;
  logic [7:0] pos_calc;

  key_lockout u_lockout (
    .i_raw(i_raw),
    .i_delta(i_delta),
    .i_group(i_group),
    .i_smask(smask),
    .i_owner(state_reg.owners),
    .o_owner(lock_owner),
    .o_det(lock_det)
  );

  slider_position u_position (
    .i_delta(i_delta[79:0]),
    .i_touch(i_raw[7:0] & smask[7:0]),
    .i_count(scount),
    .i_res(sres),
    .o_pos(pos_calc)
  );

  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  logic run_upd;
  logic status_diff;

  assign run_upd = (state_reg.phase == tsk_pkg::ST_RUN) && i_scan_done;
  assign status_diff = (lock_det != state_reg.keys) ||
                       ((|(lock_det & smask)) != state_reg.slider_det);

  always_comb begin
    state_next = state_reg;
    state_next.cycle_start = 1'b0;
    state_next.change_o = 1'b0;
    if (state_reg.phase != tsk_pkg::ST_INIT) begin
      if (state_reg.cyc_cnt == CYC_LAST) begin
        state_next.cyc_cnt = '0;
        state_next.cycle_start = 1'b1;
      end else begin
        state_next.cyc_cnt = state_reg.cyc_cnt + 1'b1;
      end
    end
    // A status read releases the pin unless a new change lands now
    if (i_status_read) begin
      state_next.change_oe_n = 1'b1;
    end
    case (state_reg.phase)
      tsk_pkg::ST_INIT: begin
        state_next.init_cnt = state_reg.init_cnt + 1'b1;
        if (state_reg.init_cnt == INIT_LAST) begin
          state_next.phase = tsk_pkg::ST_CAL;
          state_next.change_oe_n = 1'b0;
          state_next.cycle_start = 1'b1;
        end
      end
      tsk_pkg::ST_CAL: begin
        if (i_scan_done) begin
          state_next.cal_cnt = state_reg.cal_cnt + 1'b1;
          if (state_reg.cal_cnt == tsk_pkg::CAL_SCANS - 4'h1) begin
            state_next.phase = tsk_pkg::ST_RUN;
          end
        end
      end
      tsk_pkg::ST_RUN: begin
        if (i_scan_done) begin
          state_next.keys = lock_det;
          state_next.owners = lock_owner;
          state_next.slider_det = |(lock_det & smask);
          if (|(lock_det & smask)) begin
            state_next.pos = pos_calc;
          end
          if (status_diff) begin
            state_next.change_oe_n = 1'b0;
          end
        end
      end
      default: begin
        state_next.phase = tsk_pkg::ST_INIT;
      end
    endcase
    // Registered so the output never glitches on a phase decode
    state_next.calibrating = (state_next.phase == tsk_pkg::ST_CAL);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg.phase <= tsk_pkg::ST_INIT;
      state_reg.init_cnt <= '0;
      state_reg.cyc_cnt <= '0;
      state_reg.cal_cnt <= '0;
      state_reg.keys <= tsk_pkg::KEYS_RESET;
      state_reg.slider_det <= 1'b0;
      state_reg.pos <= tsk_pkg::POS_RESET;
      state_reg.owners <= {3{tsk_pkg::OWN_NONE}};
      state_reg.cycle_start <= 1'b0;
      state_reg.calibrating <= 1'b0;
      state_reg.change_o <= 1'b0;
      state_reg.change_oe_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_key_status = state_reg.keys;
  assign o_slider_det = state_reg.slider_det;
  assign o_slider_pos = state_reg.pos;
  assign o_calibrating = state_reg.calibrating;
  assign o_cycle_start = state_reg.cycle_start;
  assign o_change_o = state_reg.change_o;
  assign o_change_oe_n = state_reg.change_oe_n;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  logic [15:0] pos_limit;
  logic [1:0] sgrp;
  assign pos_limit = 16'h0001 << sres;
  assign sgrp = i_group[1:0];

  sequence cal_entry_s;
    state_reg.phase == tsk_pkg::ST_INIT && state_reg.init_cnt == INIT_LAST;
  endsequence

  sequence cal_started_s;
    o_calibrating && !o_change_oe_n && state_reg.cal_cnt == 4'h0;
  endsequence

  slider_mask_a: assert property (
    (scount >= tsk_pkg::MIN_SLIDER) |-> smask[0] && smask[8] == 1'b0 &&
    smask[scount - 4'h1] && !smask[4'(scount)])
    else $error("slider mask not contiguous from drive line zero");

  plain_keys_a: assert property (
    run_upd |=> (o_key_status & grp0) == ($past(i_raw) & $past(grp0)))
    else $error("plain key status differs from its sensed state");

  // Held position keeps the resolution it was taken at
  pos_range_a: assert property (
    run_upd && (|(lock_det & smask)) |=> 16'(o_slider_pos) < $past(pos_limit))
    else $error("slider position exceeds programmed resolution");

  slider_object_a: assert property (
    run_upd && sgrp != tsk_pkg::GRP_NONE && (|(i_raw & smask)) &&
    lock_owner[5*(sgrp - 2'h1) +: 5] == tsk_pkg::OWN_SLIDER
    |=> (o_key_status & smask) == ($past(i_raw) & $past(smask)))
    else $error("slider keys not reported as one object");

  for (genvar g = 0; g < 3; g++) begin : g_grp
    logic [15:0] gmem;
    logic own_live;
    for (genvar k = 0; k < 16; k++) begin : g_m
      assign gmem[k] = !smask[k] && i_group[2*k +: 2] == 2'(g + 1);
    end
    assign own_live = state_reg.owners[5*g +: 5] != tsk_pkg::OWN_NONE &&
      state_reg.owners[5*g +: 5] != tsk_pkg::OWN_SLIDER &&
      i_raw[state_reg.owners[5*g+:4]] &&
      gmem[state_reg.owners[5*g+:4]];

    one_per_group_a: assert property (
      $onehot0({o_key_status & gmem,
        (sgrp == 2'(g + 1)) && |(o_key_status & smask)}))
      else $error("more than one object reported in a group");

    owner_hold_a: assert property (
      run_upd && own_live |=> $stable(state_reg.owners[5*g +: 5]))
      else $error("group owner changed while still touched");
  end

  slider_multi_a: assert property (
    run_upd && (|(i_raw & smask)) && sgrp == tsk_pkg::GRP_NONE
    |=> (o_key_status & smask) == ($past(i_raw) & $past(smask)))
    else $error("slider keys suppressed each other");

  slider_blocks_a: assert property (
    o_slider_det && sgrp != tsk_pkg::GRP_NONE |->
    (o_key_status & ~smask & g_grp[0].gmem & {16{sgrp == 2'h1}}) == 16'h0000)
    else $error("slider did not suppress its group keys");

  startup_a: assert property (
    cal_entry_s |=> cal_started_s)
    else $error("calibration did not start with change low");

  change_a: assert property (
    run_upd && status_diff |=> !o_change_oe_n ##0 $changed(o_key_status) ||
    $changed(o_slider_det))
    else $error("status change without change notification");

  cycle_a: assert property (
    o_cycle_start |->
    $past(state_reg.cyc_cnt) == CYC_LAST || $past(state_reg.phase) == tsk_pkg::ST_INIT)
    else $error("cycle start off the fixed cycle");

  cycle_due_a: assert property (
    state_reg.phase != tsk_pkg::ST_INIT && state_reg.cyc_cnt == CYC_LAST |=> o_cycle_start)
    else $error("fixed cycle elapsed without a cycle start");

  position_a: assert property (
    run_upd && (|(lock_det & smask)) |=> o_slider_pos == $past(pos_calc))
    else $error("slider position not updated while touched");

endmodule
`default_nettype wire

/* File: design/tsk_pkg.sv */
// Shared constants for the touch slider and key lockout logic
package tsk_pkg;

  // ----------------------------------------
  // Matrix geometry
  // ----------------------------------------
  localparam int unsigned NUM_KEYS = 16;
  localparam int unsigned DRIVE_LINES = 8;
  localparam int unsigned DELTA_W = 10;
  localparam int unsigned GROUPS = 3;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_KHZ = 250_000;
  localparam int unsigned INIT_TIME_MS = 70;
  localparam int unsigned CYCLE_TIME_MS = 16;
  localparam int unsigned INIT_CYCLES = INIT_TIME_MS * CLK_KHZ;
  localparam int unsigned CYCLE_CYCLES = CYCLE_TIME_MS * CLK_KHZ;
  localparam int unsigned INIT_CNT_W = 25;
  localparam int unsigned CYC_CNT_W = 22;
  localparam logic [3:0] CAL_SCANS = 4'hf;

  // ----------------------------------------
  // Slider limits and encodings
  // ----------------------------------------
  localparam logic [3:0] MIN_SLIDER = 4'h2;
  localparam logic [3:0] MAX_SLIDER = 4'h8;
  localparam logic [3:0] MIN_RES = 4'h2;
  localparam logic [3:0] MAX_RES = 4'h8;
  localparam logic [1:0] GRP_NONE = 2'h0;
  localparam logic [4:0] OWN_NONE = 5'h1f;
  localparam logic [4:0] OWN_SLIDER = 5'h10;
  localparam logic [7:0] POS_RESET = 8'h00;
  localparam logic [15:0] KEYS_RESET = 16'h0000;

  typedef enum logic [1:0] {
    ST_INIT = 2'h0,
    ST_CAL = 2'h1,
    ST_RUN = 2'h3
  } phase_t;

endpackage

/* File: sim/matrix_model.sv */
// Behavioural key matrix that answers scan requests with detect and delta data
`timescale 1ns/1ns
`default_nettype none
module matrix_model (
  // Clock
  input wire logic i_clk,
  // Scan request
  input wire logic i_req,
  input wire logic [3:0] i_lag,
  input wire logic [15:0] i_touch,
  input wire logic [159:0] i_level,
  // Scan result
  output logic o_scan_done,
  output logic [15:0] o_raw,
  output logic [159:0] o_delta
);
  logic busy;
  logic [3:0] cnt;
  logic [15:0] raw_q;
  logic [159:0] delta_q;

  initial begin
    busy = 1'b0;
    cnt = 4'h0;
    o_scan_done = 1'b0;
    raw_q = 16'h0000;
    delta_q = '0;
  end

  // Scan lasts i_lag extra cycles, so the block sees slow and fast scans
  always @(posedge i_clk) begin
    o_scan_done <= 1'b0;
    if (i_req) begin
      raw_q <= i_touch;
      delta_q <= i_level;
      cnt <= i_lag;
      busy <= 1'b1;
    end else if (busy) begin
      if (cnt == 4'h0) begin
        o_scan_done <= 1'b1;
        busy <= 1'b0;
      end else begin
        cnt <= cnt - 4'h1;
      end
    end
  end

  // Results are only valid with the done pulse; show garbage otherwise
  assign o_raw = o_scan_done ? raw_q : ~raw_q;
  assign o_delta = o_scan_done ? delta_q : ~delta_q;
endmodule
`default_nettype wire

/* File: sim/tb_touch_slider_key_suppression.sv */
// Self-checking bench for the slider, key lockout and start-up logic
`timescale 1ns/1ns
`default_nettype none
module tb_touch_slider_key_suppression;
  localparam int INIT = 100;
  localparam int CYC = 50;
  logic clk, rst, req, status_read, scan_done, slider_det, calibrating, cycle_start, change_o, change_oe_n;
  logic [3:0] lag, slider_keys, slider_res;
  logic [31:0] group;
  logic [15:0] touch, raw, key_status, prev;
  logic [159:0] level, delta;
  logic [7:0] slider_pos;
  logic [9:0] d [16];
  int fail_count, total_checks;

  matrix_model u_matrix (.i_clk(clk), .i_req(req), .i_lag(lag), .i_touch(touch), .i_level(level),
    .o_scan_done(scan_done), .o_raw(raw), .o_delta(delta));

  touch_slider_core #(.INIT_CYCLES(INIT), .CYCLE_CYCLES(CYC)) DUT (.i_clk(clk), .i_rst(rst),
    .i_scan_done(scan_done), .i_raw(raw), .i_delta(delta), .i_slider_keys(slider_keys),
    .i_slider_res(slider_res), .i_group(group), .i_status_read(status_read), .o_key_status(key_status),
    .o_slider_det(slider_det), .o_slider_pos(slider_pos), .o_calibrating(calibrating),
    .o_cycle_start(cycle_start), .o_change_o(change_o), .o_change_oe_n(change_oe_n));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic complete_run;
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic clear_keys;
    for (int k = 0; k < 16; k++) begin
      d[k] = 10'h000;
    end
  endtask

  // Release change pin, run one scan, then judge status and change pin
  task automatic scan(input logic [15:0] exp, input logic det);
    int n;
    @(posedge clk);
    status_read <= 1'b1;
    @(posedge clk);
    status_read <= 1'b0;
    #1 chk(change_oe_n, 1'b1, "change release");
    @(posedge clk);
    for (int k = 0; k < 16; k++) begin
      touch[k] <= (d[k] != 10'h000);
      level[10*k +: 10] <= d[k];
    end
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    #1;
    while (scan_done !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1 chk(key_status, exp, "key status");
    chk(slider_det, det, "slider detect");
    chk(change_oe_n, exp == prev, "change on status");
    prev = exp;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_startup;
    int n;
    n = 0;
    #1;
    while (calibrating !== 1'b1 && n < INIT + 10) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n > INIT - 5 && n < INIT + 5, 1'b1, "init length");
    chk(change_oe_n, 1'b0, "change at calibration");
    chk(change_o, 1'b0, "change drive level");
    chk(cycle_start, 1'b1, "first cycle start");
    n = 0;
    @(posedge clk);
    #1 n = 1;
    while (cycle_start !== 1'b1 && n < 2 * CYC) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n[15:0], CYC[15:0], "cycle period");
    d[1] = 10'h0c8;
    d[9] = 10'h0c8;
    for (int s = 1; s <= 15; s++) begin
      scan(16'h0000, 1'b0);
      chk(calibrating, s < 15, "calibration span");
    end
    clear_keys();
  endtask

  task automatic t_lockout;
    d[1] = 10'h064;
    d[2] = 10'h064;
    scan(16'h0006, 1'b1);
    d[5] = 10'h12c;
    scan(16'h0006, 1'b1);
    d[4] = 10'h032;
    scan(16'h0016, 1'b1);
    d[1] = 10'h000;
    d[2] = 10'h000;
    scan(16'h0030, 1'b0);
    d[1] = 10'h190;
    scan(16'h0030, 1'b0);
    clear_keys();
    scan(16'h0000, 1'b0);
  endtask

  task automatic t_groups;
    @(posedge clk);
    lag <= 4'h5;
    d[6] = 10'h05a;
    d[7] = 10'h05a;
    d[8] = 10'h064;
    d[9] = 10'h032;
    d[10] = 10'h050;
    scan(16'h05c0, 1'b0);
    d[9] = 10'h12c;
    scan(16'h05c0, 1'b0);
    d[8] = 10'h000;
    scan(16'h06c0, 1'b0);
    clear_keys();
    scan(16'h0000, 1'b0);
    @(posedge clk);
    lag <= 4'h0;
  endtask

  task automatic t_position;
    logic [7:0] e;
    d[3] = 10'h0c8;
    for (int r = 2; r <= 8; r++) begin
      e = 8'hff >> (8 - r);
      @(posedge clk);
      slider_res <= r[3:0];
      scan(16'h0008, 1'b1);
      chk(slider_pos, e, "position far end");
    end
    d[3] = 10'h000;
    d[0] = 10'h0c8;
    scan(16'h0001, 1'b1);
    chk(slider_pos, 16'h0000, "position near end");
    d[0] = 10'h000;
    d[3] = 10'h0c8;
    scan(16'h0008, 1'b1);
    d[3] = 10'h000;
    scan(16'h0000, 1'b0);
    chk(slider_pos, 16'h00ff, "position held");
  endtask

  task automatic t_span;
    @(posedge clk);
    slider_keys <= 4'h2;
    d[2] = 10'h064;
    scan(16'h0004, 1'b0);
    d[2] = 10'h000;
    d[8] = 10'h064;
    scan(16'h0100, 1'b0);
    d[8] = 10'h000;
    d[0] = 10'h064;
    d[1] = 10'h064;
    scan(16'h0003, 1'b1);
    @(posedge clk);
    group <= 32'h003a_0450;
    d[5] = 10'h12c;
    scan(16'h0023, 1'b1);
    clear_keys();
    scan(16'h0000, 1'b0);
    @(posedge clk);
    slider_keys <= 4'h1;
    group <= 32'h003a_0455;
    d[0] = 10'h064;
    d[1] = 10'h032;
    scan(16'h0001, 1'b0);
  endtask

  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #100000;
    fail_count++;
    complete_run();
  end

  initial begin
    rst = 1'b1;
    req = 1'b0;
    status_read = 1'b0;
    lag = 4'h0;
    slider_keys = 4'h4;
    slider_res = 4'h8;
    group = 32'h003a_0455;
    touch = 16'h0000;
    level = '0;
    prev = 16'h0000;
    fail_count = 0;
    total_checks = 0;
    clear_keys();
    repeat (3) @(posedge clk);
    #1 chk({key_status[7:0], slider_pos}, 16'h0000, "reset status");
    chk({slider_det, calibrating, cycle_start, change_o, change_oe_n}, 16'h0001, "reset flags");
    @(posedge clk);
    rst <= 1'b0;
    t_startup();
    t_lockout();
    t_groups();
    t_position();
    t_span();
    complete_run();
  end
endmodule
`default_nettype wire
